//--- rtl/cache_sweep_cycle_control.v
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "sweep_defines.vh"


module cache_sweep_cycle_control #(
  parameter ADDR_W = 12
) (
  input  wire               sys_clk_i,
  input  wire               reset_n_i,
  input  wire               psel_i,
  input  wire               penable_i,
  input  wire               pwrite_i,
  input  wire [ADDR_W-1:0]  paddr_i,
  input  wire [31:0]        pwdata_i,
  output reg  [31:0]        prdata_o,
  output reg                pready_o,
  output reg                pslverr_o,
  input  wire               mb_req_i,
  input  wire               chan_req_i,
  input  wire               exec_req_i,
  input  wire               core_busy_i,
  input  wire               exec_cycle_done_i,
  input  wire               exec_unit_sync_i,
  input  wire               any_valid_match_i,
  input  wire               any_written_match_i,
  input  wire               writeback_done_i,
  output wire               sweep_request_flag_o,
  output reg                sweep_cycle_flag_o,
  output reg                physical_address_mux_sweep_o,
  output wire [21:0]        cache_address_o,
  output wire               writeback_start_o,
  output wire               invalidate_o,
  output wire               block_select_hold_o,
  output wire               force_valid_match_o,
  output reg  [1:0]         force_block_o
);

  // ********************************************************************
  // Sequencer states
  // ********************************************************************
  localparam [10:0] ST_IDLE = 11'h001;
  localparam [10:0] ST_GO   = 11'h002;
  localparam [10:0] ST_T0   = 11'h004;
  localparam [10:0] ST_T1   = 11'h008;
  localparam [10:0] ST_T2   = 11'h010;
  localparam [10:0] ST_T3   = 11'h020;
  localparam [10:0] ST_WB   = 11'h040;
  localparam [10:0] ST_WBW  = 11'h080;
  localparam [10:0] ST_INV  = 11'h100;
  localparam [10:0] ST_DONE = 11'h200;
  localparam [10:0] ST_BACK = 11'h400;
  // Strobe taps into the one-hot state word
  localparam        WB_STATE_BIT  = 6;
  localparam        INV_STATE_BIT = 8;

  reg  [10:0]       state_q;
  reg  [10:0]       state_d;
  reg  [2:0]        qual_reg_q;
  reg               single_page_q;
  reg               writeback_q;
  reg               invalidate_q;
  reg               request_q;
  reg               second_pass_q;
  reg               prev_exec_q;
  reg               apb_done_q;
  reg               force_valid_q;
  reg  [31:0]       status_word;
  wire              apb_access;
  wire              apb_write;
  wire              sweep_grant;
  wire              load_sweep;
  wire              step_addr;
  wire              carry;
  wire              exec_hold;
  wire [21:0]       sweep_addr;
  wire              line_match;
  wire              written_match;

  // ********************************************************************
  // APB register decode
  // ********************************************************************
  function [1:0] reg_hit;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `SWEEP_ADDR_OFFSET:   reg_hit = 2'h1;
        `SWEEP_QUAL_OFFSET:   reg_hit = 2'h2;
        `SWEEP_STATUS_OFFSET: reg_hit = 2'h3;
        default:              reg_hit = 2'h0;
      endcase
    end
  endfunction

  assign apb_access = psel_i & penable_i & ~apb_done_q;
  // Writes land on the edge that completes the transfer
  assign apb_write  = psel_i & penable_i & pready_o & pwrite_i;
  assign load_sweep = apb_write & (reg_hit(paddr_i) == 2'h1);

  // Fields placed by the shared bit positions so software and logic agree
  always @* begin
    status_word                        = 32'h00000000;
    status_word[`STAT_REQUEST_BIT]     = request_q;
    status_word[`STAT_CYCLE_BIT]       = sweep_cycle_flag_o;
    status_word[`STAT_SECOND_PASS_BIT] = second_pass_q;
    status_word[`STAT_STATE_LSB +: 11] = state_q;
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      prdata_o   <= 32'h00000000;
      apb_done_q <= 1'b0;
    end else begin
      pready_o   <= apb_access;
      apb_done_q <= apb_access;
      if (apb_access) begin
        pslverr_o <= (reg_hit(paddr_i) == 2'h0);
        if (pwrite_i) begin
          prdata_o <= 32'h00000000;
        end else begin
          case (reg_hit(paddr_i))
            2'h1:    prdata_o <= {10'h000, sweep_addr};
            2'h2:    prdata_o <= {29'h00000000, qual_reg_q};
            2'h3:    prdata_o <= status_word;
            default: prdata_o <= 32'h00000000;
          endcase
        end
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      qual_reg_q <= `SWEEP_QUAL_RESET;
    end else if (apb_write && (reg_hit(paddr_i) == 2'h2)) begin
      qual_reg_q <= pwdata_i[2:0];
    end
  end

  // ********************************************************************
  // Sweep start and request flag
  // ********************************************************************
  // Qualifiers frozen at start so a rewrite cannot bend a running sweep
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      single_page_q <= 1'b0;
      writeback_q   <= 1'b0;
      invalidate_q  <= 1'b0;
      request_q     <= 1'b0;
    end else begin
      if (load_sweep) begin
        single_page_q <= qual_reg_q[`QUAL_SINGLE_PAGE_BIT];
        writeback_q   <= qual_reg_q[`QUAL_WRITEBACK_BIT];
        invalidate_q  <= qual_reg_q[`QUAL_INVALIDATE_BIT];
        request_q     <= 1'b1;
      end else if ((state_q == ST_DONE) && carry) begin
        request_q     <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Execution-unit hand-off and arbitration
  // ********************************************************************
  // Execution-unit data hand-off tracking, set wins over clear
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      prev_exec_q <= 1'b0;
    end else if (exec_cycle_done_i) begin
      prev_exec_q <= 1'b1;
    end else if (exec_unit_sync_i) begin
      prev_exec_q <= 1'b0;
    end
  end

  assign exec_hold = prev_exec_q & ~exec_unit_sync_i;

  sweep_grant_arbiter u_arbiter (
    .sweep_req_i   (request_q),
    .mb_req_i      (mb_req_i),
    .chan_req_i    (chan_req_i),
    .exec_req_i    (exec_req_i),
    .core_busy_i   (core_busy_i),
    .other_req_o   (),
    .sweep_grant_o (sweep_grant)
  );

  // ********************************************************************
  // Sweep address counter
  // ********************************************************************
  assign step_addr = (state_q == ST_DONE);

  sweep_addr_counter #(
    .ADDR_W (22)
  ) u_counter (
    .sys_clk_i     (sys_clk_i),
    .reset_n_i     (reset_n_i),
    .load_i        (load_sweep),
    .load_value_i  (pwdata_i[21:0]),
    .step_i        (step_addr),
    .single_page_i (single_page_q),
    .addr_o        (sweep_addr),
    .carry_o       (carry)
  );

  // ********************************************************************
  // Lookup qualification
  // ********************************************************************
  // All pages forces the match; the directory compare only matters per page
  assign line_match    = single_page_q ? any_valid_match_i : 1'b1;
  assign written_match = any_written_match_i & line_match;

  // ********************************************************************
  // State sequencer
  // ********************************************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (!exec_hold && sweep_grant) begin
          state_d = ST_GO;
        end
      end
      ST_GO: begin
        state_d = ST_T0;
      end
      ST_T0: begin
        state_d = ST_T1;
      end
      ST_T1: begin
        state_d = ST_T2;
      end
      ST_T2: begin
        state_d = ST_T3;
      end
      ST_T3: begin
        if (!line_match) begin
          state_d = ST_DONE;
        end else if (writeback_q && !second_pass_q && written_match) begin
          state_d = ST_WB;
        end else if (invalidate_q) begin
          state_d = ST_INV;
        end else begin
          state_d = ST_DONE;
        end
      end
      ST_WB: begin
        state_d = ST_WBW;
      end
      ST_WBW: begin
        if (writeback_done_i) begin
          state_d = invalidate_q ? ST_BACK : ST_DONE;
        end
      end
      ST_INV: begin
        state_d = ST_DONE;
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      ST_BACK: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Second pass reuses the same address, no step between passes
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      second_pass_q <= 1'b0;
    end else if (state_q == ST_BACK) begin
      second_pass_q <= 1'b1;
    end else if ((state_q == ST_DONE) || load_sweep) begin
      second_pass_q <= 1'b0;
    end
  end

  // ********************************************************************
  // Cycle flag and address source
  // ********************************************************************
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sweep_cycle_flag_o           <= 1'b0;
      physical_address_mux_sweep_o <= 1'b0;
      force_valid_q                <= 1'b0;
      force_block_o                <= 2'h0;
    end else begin
      if (state_d == ST_GO) begin
        sweep_cycle_flag_o           <= 1'b1;
        physical_address_mux_sweep_o <= 1'b1;
        force_valid_q                <= ~single_page_q;
      end else if (state_d == ST_IDLE) begin
        sweep_cycle_flag_o           <= 1'b0;
        physical_address_mux_sweep_o <= 1'b0;
        force_valid_q                <= 1'b0;
      end
      force_block_o <= sweep_addr[`WORD_SEL_MSB:0];
    end
  end

  // ********************************************************************
  // Action strobes straight from state flip-flops
  // ********************************************************************
  assign sweep_request_flag_o = request_q;
  assign cache_address_o      = sweep_addr;
  assign writeback_start_o    = state_q[WB_STATE_BIT];
  assign invalidate_o         = state_q[INV_STATE_BIT];
  assign block_select_hold_o  = state_q[INV_STATE_BIT];
  assign force_valid_match_o  = force_valid_q;

endmodule

//--- rtl/sweep_defines.vh
`ifndef SWEEP_DEFINES_VH
`define SWEEP_DEFINES_VH

// ********************************************************************
// Register map, byte addresses on the APB side
// ********************************************************************
`define SWEEP_ADDR_OFFSET      12'h000
`define SWEEP_QUAL_OFFSET      12'h004
`define SWEEP_STATUS_OFFSET    12'h008

// ********************************************************************
// Field positions
// ********************************************************************
`define QUAL_SINGLE_PAGE_BIT   0
`define QUAL_WRITEBACK_BIT     1
`define QUAL_INVALIDATE_BIT    2
`define STAT_REQUEST_BIT       0
`define STAT_CYCLE_BIT         1
`define STAT_SECOND_PASS_BIT   2
`define STAT_STATE_LSB         8

// Sweep address is 22 bits, bit 0 here is word bit 35, bit 21 is word bit 14
`define SWEEP_ADDR_WIDTH       22
`define PAGE_FIELD_MSB         21
`define PAGE_FIELD_LSB         9
`define BLOCK_FIELD_MSB        8
`define LINE_FIELD_LSB         2
`define WORD_SEL_MSB           1

// ********************************************************************
// Reset values
// ********************************************************************
`define SWEEP_ADDR_RESET       22'h000000
`define SWEEP_QUAL_RESET       3'h0

// ********************************************************************
// Step sizes of the sweep address
// ********************************************************************
`define STEP_PER_LINE          9'h004
`define STEP_PER_BLOCK         9'h001

`endif

//--- rtl/sweep_addr_counter.v
`timescale 1ns/1ps
`include "sweep_defines.vh"

module sweep_addr_counter #(
  parameter ADDR_W = `SWEEP_ADDR_WIDTH
) (
  input  wire              sys_clk_i,
  input  wire              reset_n_i,
  input  wire              load_i,
  input  wire [ADDR_W-1:0] load_value_i,
  input  wire              step_i,
  input  wire              single_page_i,
  output wire [ADDR_W-1:0] addr_o,
  output wire              carry_o
);

  reg  [ADDR_W-1:0] addr_q;
  wire [8:0]        low_field;
  wire [8:0]        step_size;

  assign low_field = addr_q[`BLOCK_FIELD_MSB:0];
  assign step_size = single_page_i ? `STEP_PER_LINE : `STEP_PER_BLOCK;
  // Carry out of the line counter, or of the whole block counter
  assign carry_o   = single_page_i ? (addr_q[`BLOCK_FIELD_MSB:`LINE_FIELD_LSB] == 7'h00) : (low_field == 9'h000);
  assign addr_o    = addr_q;

  // Page bits stay put so one-page compares keep their target
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      addr_q <= `SWEEP_ADDR_RESET;
    end else if (load_i) begin
      addr_q <= load_value_i;
    end else if (step_i) begin
      addr_q[`BLOCK_FIELD_MSB:0] <= low_field - step_size;
    end
  end

endmodule

//--- rtl/sweep_grant_arbiter.v
`timescale 1ns/1ps

module sweep_grant_arbiter (
  input  wire sweep_req_i,
  input  wire mb_req_i,
  input  wire chan_req_i,
  input  wire exec_req_i,
  input  wire core_busy_i,
  output wire other_req_o,
  output wire sweep_grant_o
);

  // Sweep yields to every other requester and to a busy core
  assign other_req_o   = mb_req_i | chan_req_i | exec_req_i;
  assign sweep_grant_o = sweep_req_i & ~other_req_o & ~core_busy_i;

endmodule

//--- tb/sweep_control_properties.sv
`timescale 1ns/1ps
module sweep_control_checker #(
  parameter ADDR_W = 12
) (
  input wire              sys_clk_i,
  input wire              reset_n_i,
  input wire              psel_i,
  input wire              penable_i,
  input wire              pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire              pready_o,
  input wire              mb_req_i,
  input wire              chan_req_i,
  input wire              exec_req_i,
  input wire              core_busy_i,
  input wire              sweep_request_flag_o,
  input wire              sweep_cycle_flag_o,
  input wire              physical_address_mux_sweep_o,
  input wire [21:0]       cache_address_o,
  input wire              writeback_start_o,
  input wire              invalidate_o,
  input wire              block_select_hold_o,
  input wire              force_valid_match_o,
  input wire [1:0]        force_block_o
);
  // ****
  // Helper: address load seen last edge
  // ****
  wire load_w;
  reg  load_q;
  assign load_w = psel_i & penable_i & pwrite_i & pready_o & (paddr_i == {ADDR_W{1'b0}});
  always @(posedge sys_clk_i) begin
    load_q <= load_w;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  grant_priority_a: assert property ($rose(sweep_cycle_flag_o) |->
    $past(!mb_req_i && !chan_req_i && !exec_req_i && !core_busy_i && sweep_request_flag_o))
    else $error("sweep cycle began while blocked");
  go_mux_a: assert property ($rose(sweep_cycle_flag_o) |-> physical_address_mux_sweep_o)
    else $error("address mux not on sweep source");
  lookup_delay_a: assert property ($rose(sweep_cycle_flag_o) |->
    (sweep_cycle_flag_o && !invalidate_o && !writeback_start_o)[*5])
    else $error("action before lookup delay ended");
  hold_match_a: assert property ((invalidate_o || block_select_hold_o) |->
    (invalidate_o && block_select_hold_o && sweep_cycle_flag_o))
    else $error("invalidate and block hold differ");
  wb_pulse_a: assert property (writeback_start_o |-> !invalidate_o ##1 !writeback_start_o)
    else $error("writeback start not a lone pulse");
  inval_done_a: assert property (invalidate_o |=> sweep_cycle_flag_o ##1 !sweep_cycle_flag_o)
    else $error("done state not after invalidate");
  force_match_a: assert property (force_valid_match_o |-> sweep_cycle_flag_o)
    else $error("forced match outside sweep cycle");
  forced_block_a: assert property ((force_valid_match_o && !load_q) |-> (force_block_o == cache_address_o[1:0]))
    else $error("forced block not address low bits");
  end_clear_a: assert property ($fell(sweep_request_flag_o) |-> $fell(sweep_cycle_flag_o))
    else $error("request cleared outside done state");
  addr_step_a: assert property ((!load_q && cache_address_o != $past(cache_address_o)) |->
    (cache_address_o[21:9] == $past(cache_address_o[21:9])) &&
    (($past(cache_address_o[8:0]) - cache_address_o[8:0]) inside {9'h001, 9'h004}))
    else $error("sweep address stepped wrongly");
  cover property ($rose(sweep_cycle_flag_o));
  cover property (writeback_start_o);
  cover property ($fell(sweep_request_flag_o));
endmodule
bind cache_sweep_cycle_control sweep_control_checker #(.ADDR_W(ADDR_W)) u_chk (.sys_clk_i, .reset_n_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .mb_req_i, .chan_req_i, .exec_req_i, .core_busy_i,
  .sweep_request_flag_o, .sweep_cycle_flag_o, .physical_address_mux_sweep_o, .cache_address_o,
  .writeback_start_o, .invalidate_o, .block_select_hold_o, .force_valid_match_o, .force_block_o);

//--- tb/exec_core_model.sv
`timescale 1ns/1ps
module exec_core_model (
  input  wire       sys_clk_i,
  input  wire       reset_n_i,
  input  wire       exec_serve_i,
  input  wire       writeback_start_i,
  input  wire [3:0] wb_wait_i,
  output reg        core_busy_o,
  output reg        writeback_done_o,
  output reg        exec_cycle_done_o,
  output reg        exec_unit_sync_o
);
  reg [4:0] sync_cnt_q;
  reg [3:0] wb_cnt_q;
  // ****
  // Slow exec unit, core write held busy
  // ****
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      {core_busy_o, writeback_done_o, exec_cycle_done_o, exec_unit_sync_o} <= 4'h0;
      sync_cnt_q <= 5'h00;
      wb_cnt_q   <= 4'h0;
    end else begin
      exec_cycle_done_o <= exec_serve_i;
      writeback_done_o  <= 1'b0;
      // Sync comes late on purpose to hold the sequencer in idle
      if (exec_serve_i) sync_cnt_q <= 5'h14;
      else if (sync_cnt_q != 5'h00) sync_cnt_q <= sync_cnt_q - 5'h01;
      exec_unit_sync_o <= (sync_cnt_q == 5'h01);
      if (writeback_start_i) begin
        core_busy_o <= 1'b1;
        wb_cnt_q    <= wb_wait_i;
      end else if (core_busy_o) begin
        if (wb_cnt_q == 4'h0) begin
          core_busy_o      <= 1'b0;
          writeback_done_o <= 1'b1;
        end else wb_cnt_q <= wb_cnt_q - 4'h1;
      end
    end
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic        sys_clk_i = 1'b0, reset_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        valid_m = 1'b0, written_m = 1'b0, exec_serve = 1'b0, slverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic [3:0]  blockers = 4'h0, wb_wait = 4'h0;
  wire  [31:0] prdata;
  wire  [21:0] cache_addr;
  wire         pready, pslverr, req_flag, cyc_flag, model_busy, wb_done, exec_done, sync, wb_start, inval;
  int          fail_count = 0, tests_run = 0, inv_n = 0, wb_n = 0;
  logic [2:0]  t_qual [0:5] = '{3'h4, 3'h2, 3'h6, 3'h5, 3'h7, 3'h7};
  logic [21:0] t_addr [0:5] = '{22'h000002, 22'h000001, 22'h000001, 22'h357604, 22'h357604, 22'h357600};
  logic [4:0]  t_blk  [0:5] = '{5'h0F, 5'h00, 5'h10, 5'h00, 5'h00, 5'h00};
  logic [1:0]  t_vw   [0:5] = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h3};
  int          t_wb   [0:5] = '{0, 2, 2, 0, 0, 1};
  int          t_inv  [0:5] = '{3, 0, 2, 2, 0, 1};

  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (inval === 1'b1) inv_n++;
    if (wb_start === 1'b1) wb_n++;
  end

  cache_sweep_cycle_control i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .mb_req_i(blockers[0]), .chan_req_i(blockers[1]),
    .exec_req_i(blockers[2]), .core_busy_i(blockers[3] | model_busy), .exec_cycle_done_i(exec_done),
    .exec_unit_sync_i(sync), .any_valid_match_i(valid_m), .any_written_match_i(written_m),
    .writeback_done_i(wb_done), .sweep_request_flag_o(req_flag), .sweep_cycle_flag_o(cyc_flag),
    .physical_address_mux_sweep_o(), .cache_address_o(cache_addr), .writeback_start_o(wb_start),
    .invalidate_o(inval), .block_select_hold_o(), .force_valid_match_o(), .force_block_o());
  exec_core_model i_model (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .exec_serve_i(exec_serve),
    .writeback_start_i(wb_start), .wb_wait_i(wb_wait), .core_busy_o(model_busy),
    .writeback_done_o(wb_done), .exec_cycle_done_o(exec_done), .exec_unit_sync_o(sync));

  // ****
  // Shared tasks
  // ****
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  // Held until pready seen at an edge, released only after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      conclude();
    end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    check("status", rd, 32'h00000100);
    apb(1'b0, 12'h000, 32'h0);
    check("address", rd, 32'h00000000);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped err", {31'h0, slverr}, 32'h00000001);
    for (int i = 0; i < 6; i++) begin
      valid_m <= t_vw[i][1];
      written_m <= t_vw[i][0];
      wb_wait <= (i == 1) ? 4'h9 : 4'h1;
      inv_n = 0;
      wb_n = 0;
      if (t_blk[i][3:0] != 4'h0) blockers <= 4'h1;
      apb(1'b1, 12'h004, {29'h0, t_qual[i]});
      if (t_blk[i][4]) begin
        exec_serve <= 1'b1;
        @(posedge sys_clk_i);
        exec_serve <= 1'b0;
      end
      apb(1'b1, 12'h000, {10'h0, t_addr[i]});
      for (int b = 0; b < 4; b++) if (t_blk[i][b]) begin
        blockers <= 4'h1 << b;
        repeat (6) @(posedge sys_clk_i);
        check("blocked", {31'h0, cyc_flag}, 32'h0);
      end
      blockers <= 4'h0;
      if (t_blk[i][4]) begin
        repeat (8) @(posedge sys_clk_i);
        check("sync stall", {31'h0, cyc_flag}, 32'h0);
      end
      for (int n = 0; n <= 3000; n++) begin
        @(posedge sys_clk_i);
        if (req_flag === 1'b0) break;
        if (n == 3000) begin
          fail_count++;
          conclude();
        end
      end
      check("writebacks", 32'(wb_n), 32'(t_wb[i]));
      check("invalidates", 32'(inv_n), 32'(t_inv[i]));
      check("page kept", {19'h0, cache_addr[21:9]}, {19'h0, t_addr[i][21:9]});
      check("addr wrapped", {23'h0, cache_addr[8:0]},
            {23'h0, t_qual[i][0] ? {7'h7F, t_addr[i][1:0]} : 9'h1FF});
      apb(1'b0, 12'h008, 32'h0);
      check("request off", rd, 32'h00000100);
    end
    conclude();
  end
endmodule
